// File: design/input_cond_pkg.sv
/*
  Shared constants and carrier types for the scanner input conditioner.
  Assumes a 10 MHz system clock; all times are converted to cycle counts here.
*/
package input_cond_pkg;

  // ==========================================================
  // clock and debounce timing
  localparam int unsigned CLOCK_HZ = 10_000_000;
  localparam int unsigned DEBOUNCE_LONG_US = 5000;
  localparam int unsigned DEBOUNCE_SHORT_US = 500;
  localparam int unsigned DEBOUNCE_LONG_CYCLES = (DEBOUNCE_LONG_US * (CLOCK_HZ / 1_000_000));
  localparam int unsigned DEBOUNCE_SHORT_CYCLES = (DEBOUNCE_SHORT_US * (CLOCK_HZ / 1_000_000));
  localparam int unsigned DEBOUNCE_COUNT_WIDTH = 16;

  // ==========================================================
  // speed measurement window
  localparam int unsigned SPEED_WINDOW_US = 100_000;
  localparam int unsigned SPEED_WINDOW_CYCLES = (SPEED_WINDOW_US * (CLOCK_HZ / 1_000_000));
  localparam int unsigned SPEED_COUNT_WIDTH = 16;

  // ==========================================================
  // reset values
  localparam logic SYNC_RESET_LEVEL = 1'b0;
  localparam logic FILTER_RESET_LEVEL = 1'b0;

  // ==========================================================
  // operating modes
  typedef enum logic [1:0] {
    mode_free_running = 2'h0,
    mode_host_triggered = 2'h1,
    mode_conveyor_tracking = 2'h2
  } operating_mode_e;

  // ==========================================================
  // reading phase states, one-hot
  typedef enum logic [1:0] {
    phase_idle = 2'h1,
    phase_reading = 2'h2
  } phase_state_e;

  // per-input configuration: 1 = active closed, 1 = short debounce
  typedef struct packed {
    logic [3:0] active_closed;
    logic shared_short_debounce;
    logic encoder_short_debounce;
  } input_config_s;

  // logical asserted levels after polarity
  typedef struct packed {
    logic trigger_input;
    logic encoder_input;
    logic generic_input_a;
    logic generic_input_b;
  } input_state_s;

endpackage

// File: design/debounce_filter.sv
/*
  One input channel: two-stage synchroniser followed by a debounce filter.
  Assumes the delay select is quasi-static; a change restarts nothing.
*/
`timescale 1ns/1ps

module debounce_filter
  import input_cond_pkg::*;
#(
  parameter int unsigned LONG_CYCLES = DEBOUNCE_LONG_CYCLES,
  parameter int unsigned SHORT_CYCLES = DEBOUNCE_SHORT_CYCLES
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // line and settings
  input wire logic line_in,
  input wire logic short_delay_in,
  // filtered level
  output logic level_out
);

  // ==========================================================
  // synchroniser
  logic sync_first;
  logic sync_second;
  logic level;
  logic [DEBOUNCE_COUNT_WIDTH-1:0] count;
  logic next_level;
  logic [DEBOUNCE_COUNT_WIDTH-1:0] next_count;
  logic [DEBOUNCE_COUNT_WIDTH-1:0] limit;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      sync_first <= SYNC_RESET_LEVEL;
      sync_second <= SYNC_RESET_LEVEL;
    end else begin
      sync_first <= line_in;
      sync_second <= sync_first;
    end
  end

  // ==========================================================
  // debounce counter
  always_comb begin
    // pick 5 ms or 500 us
    limit = short_delay_in ? DEBOUNCE_COUNT_WIDTH'(SHORT_CYCLES - 1)
                           : DEBOUNCE_COUNT_WIDTH'(LONG_CYCLES - 1);
    next_level = level;
    next_count = count;
    if (sync_second == level) begin
      next_count = '0;
    end else if (count >= limit) begin
      next_level = sync_second;
      next_count = '0;
    end else begin
      next_count = count + DEBOUNCE_COUNT_WIDTH'(1);
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      level <= FILTER_RESET_LEVEL;
      count <= '0;
    end else begin
      level <= next_level;
      count <= next_count;
    end
  end

  assign level_out = level;

endmodule

// File: design/scanner_input_conditioner.sv
/*
  Conditioning of the four command inputs of a code scanner: sync, debounce,
  polarity, trigger/stop phase control, encoder speed and verifier capture.
  Assumes optocoupled lines already converted to logic levels (1 = current flows),
  asynchronous to the 10 MHz clock_in, and software settings held on plain ports.
*/
//
// Contract
// - four inputs with fixed roles: trigger, encoder and two generic inputs.
// - every input passes a debounce filter of either 5 ms or 500 us.
// - trigger and both generic inputs share one debounce setting.
// - the encoder input has its own debounce setting, normally 500 us.
// - each input has a selectable active-open or active-closed sense.
// - in host-triggered and conveyor-tracking modes the trigger starts scanning.
// - the phase indicator follows the debounced current on the trigger line, not its logic.
// - in conveyor-tracking mode conveyor speed is measured from encoder pulses.
// - when enabled, either generic input asserted ends the reading phase.
// - with verification on and the chosen input asserted, the next good read is stored.
`timescale 1ns/1ps

module scanner_input_conditioner
  import input_cond_pkg::*;
#(
  parameter int unsigned LONG_CYCLES = DEBOUNCE_LONG_CYCLES,
  parameter int unsigned SHORT_CYCLES = DEBOUNCE_SHORT_CYCLES,
  parameter int unsigned WINDOW_CYCLES = SPEED_WINDOW_CYCLES
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // input lines, 1 = current flowing
  input wire logic trigger_input_in,
  input wire logic encoder_input_in,
  input wire logic generic_input_a_in,
  input wire logic generic_input_b_in,
  // software settings
  input wire input_config_s config_in,
  input wire operating_mode_e mode_in,
  input wire logic generic_stop_enable_in,
  input wire logic verifier_enable_in,
  input wire logic [1:0] verifier_input_select_in,
  // decoder side
  input wire logic code_read_ok_in,
  // status and commands
  output input_state_s state_out,
  output logic phase_indicator_out,
  output logic reading_phase_out,
  output logic scan_start_out,
  output logic scan_stop_out,
  output logic [SPEED_COUNT_WIDTH-1:0] encoder_speed_out,
  output logic speed_valid_out,
  output logic encoder_pulse_out,
  output logic verifier_armed_out,
  output logic verifier_store_out
);

  // ==========================================================
  // filters
  logic [3:0] raw_lines;
  logic [3:0] filtered;
  logic [3:0] short_sel;

  assign raw_lines = {trigger_input_in, encoder_input_in, generic_input_a_in,
                      generic_input_b_in};
  assign short_sel = {config_in.shared_short_debounce, config_in.encoder_short_debounce,
                      config_in.shared_short_debounce, config_in.shared_short_debounce};

  for (genvar i = 0; i < 4; i++) begin : g_filter
    debounce_filter #(
      .LONG_CYCLES(LONG_CYCLES),
      .SHORT_CYCLES(SHORT_CYCLES)
    ) u_filter (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .line_in(raw_lines[i]),
      .short_delay_in(short_sel[i]),
      .level_out(filtered[i])
    );
  end

  // ==========================================================
  // polarity and edges
  logic [3:0] asserted;
  logic [3:0] asserted_prev;
  logic [3:0] rise;
  input_state_s next_state;
  logic next_indicator;

  assign asserted = ~(filtered ^ config_in.active_closed);
  assign rise = asserted & ~asserted_prev;

  always_comb begin
    next_state = input_state_s'(asserted);
    next_indicator = filtered[3];
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      asserted_prev <= 4'h0;
      state_out <= '0;
      phase_indicator_out <= 1'b0;
    end else begin
      asserted_prev <= asserted;
      state_out <= next_state;
      phase_indicator_out <= next_indicator;
    end
  end

  // ==========================================================
  // reading phase control
  phase_state_e phase;
  phase_state_e next_phase;
  logic trig_mode;
  logic stop_req;
  logic next_start;
  logic next_stop;

  assign trig_mode = (mode_in == mode_host_triggered) || (mode_in == mode_conveyor_tracking);
  assign stop_req = generic_stop_enable_in && (rise[1] || rise[0]);

  always_comb begin
    next_phase = phase;
    next_start = 1'b0;
    next_stop = 1'b0;
    case (phase)
      phase_idle: begin
        if (trig_mode && rise[3]) begin
          next_phase = phase_reading;
          next_start = 1'b1;
        end
      end
      phase_reading: begin
        // trigger release closes the phase only while generic stop is disabled
        if (stop_req || (trig_mode && !asserted[3] && !generic_stop_enable_in)) begin
          next_phase = phase_idle;
          next_stop = 1'b1;
        end
      end
      default: begin
        next_phase = phase_idle;
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      phase <= phase_idle;
      scan_start_out <= 1'b0;
      scan_stop_out <= 1'b0;
    end else begin
      phase <= next_phase;
      scan_start_out <= next_start;
      scan_stop_out <= next_stop;
    end
  end

  assign reading_phase_out = (phase == phase_reading);

  // ==========================================================
  // encoder speed
  logic [31:0] window_count;
  logic [SPEED_COUNT_WIDTH-1:0] pulse_count;
  logic [31:0] next_window_count;
  logic [SPEED_COUNT_WIDTH-1:0] next_pulse_count;
  logic [SPEED_COUNT_WIDTH-1:0] next_speed;
  logic next_speed_valid;
  logic next_enc_pulse;
  logic track_mode;

  assign track_mode = (mode_in == mode_conveyor_tracking);

  // 1 kHz cap keeps counts small
  always_comb begin
    next_window_count = window_count;
    next_pulse_count = pulse_count;
    next_speed = encoder_speed_out;
    next_speed_valid = 1'b0;
    next_enc_pulse = track_mode && rise[2];
    if (!track_mode) begin
      next_window_count = 32'h0;
      next_pulse_count = '0;
    end else if (window_count >= 32'(WINDOW_CYCLES - 1)) begin
      next_window_count = 32'h0;
      next_speed = pulse_count + SPEED_COUNT_WIDTH'(rise[2]);
      next_speed_valid = 1'b1;
      next_pulse_count = '0;
    end else begin
      next_window_count = window_count + 32'h1;
      next_pulse_count = pulse_count + SPEED_COUNT_WIDTH'(rise[2]);
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      window_count <= 32'h0;
      pulse_count <= '0;
      encoder_speed_out <= '0;
      speed_valid_out <= 1'b0;
      encoder_pulse_out <= 1'b0;
    end else begin
      window_count <= next_window_count;
      pulse_count <= next_pulse_count;
      encoder_speed_out <= next_speed;
      speed_valid_out <= next_speed_valid;
      encoder_pulse_out <= next_enc_pulse;
    end
  end

  // ==========================================================
  // verifier capture
  logic armed;
  logic next_armed;
  logic next_store;
  logic sel_rise;

  // select: 0 trigger, 1 encoder, 2 generic a, 3 generic b
  assign sel_rise = rise[2'h3 - verifier_input_select_in];

  always_comb begin
    next_armed = armed;
    next_store = 1'b0;
    if (!verifier_enable_in) begin
      next_armed = 1'b0;
    end else if (armed && code_read_ok_in) begin
      next_store = 1'b1;
      next_armed = sel_rise;
    end else if (sel_rise) begin
      next_armed = 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      armed <= 1'b0;
      verifier_store_out <= 1'b0;
    end else begin
      armed <= next_armed;
      verifier_store_out <= next_store;
    end
  end

  assign verifier_armed_out = armed;

endmodule

// File: bench/input_cond_checker.sv
/* Port checker for the scanner input conditioner.
   Sees only the top module's ports; bound at the foot of this file. */
`timescale 1ns/1ps
module input_cond_checker
  import input_cond_pkg::*;
#(
  parameter int unsigned SHORT_CYCLES = 5
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // inputs watched
  input wire logic trigger_input_in,
  input wire input_config_s config_in,
  input wire operating_mode_e mode_in,
  input wire logic code_read_ok_in,
  // outputs watched
  input wire input_state_s state_out,
  input wire logic phase_indicator_out,
  input wire logic reading_phase_out,
  input wire logic scan_start_out,
  input wire logic scan_stop_out,
  input wire logic encoder_pulse_out,
  input wire logic verifier_armed_out,
  input wire logic verifier_store_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // ==========================================
  // cycles the raw trigger line has held
  logic [15:0] held;
  logic [15:0] next_held;
  logic last_line;
  always_comb begin
    next_held = (trigger_input_in != last_line) ? 16'h0 : (held == 16'hffff) ? held : held + 16'h1;
  end
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      held <= 16'h0;
      last_line <= 1'b0;
    end else begin
      held <= next_held;
      last_line <= trigger_input_in;
    end
  end
  // ==========================================
  // assertions
  // start pulse and state_out leave the same edge, so the mode is the one of the cycle before
  chk_start_mode: assert property (scan_start_out |->
    $past(mode_in) != mode_free_running)
    else $error("scan start in free mode");
  chk_start_cause: assert property (scan_start_out |->
    state_out.trigger_input && !$past(state_out.trigger_input) && !$past(reading_phase_out))
    else $error("scan start without trigger");
  chk_start_phase: assert property (scan_start_out |-> ##[0:1] reading_phase_out)
    else $error("reading phase not entered");
  chk_start_single: assert property (scan_start_out |=> !scan_start_out)
    else $error("scan start longer than one cycle");
  chk_stop_phase: assert property (scan_stop_out |-> ##[0:1] !reading_phase_out)
    else $error("reading phase not left");
  chk_indicator_raw: assert property (!$past(reset_in) && $stable(config_in) |->
    state_out.trigger_input == (phase_indicator_out ~^ config_in.active_closed[3]))
    else $error("indicator and trigger state disagree");
  chk_settle_time: assert property ($changed(phase_indicator_out) |->
    $past(held, 3) + 16'h2 >= SHORT_CYCLES)
    else $error("filter changed before delay");
  chk_enc_mode: assert property (encoder_pulse_out |->
    $past(mode_in) == mode_conveyor_tracking)
    else $error("encoder pulse outside tracking mode");
  chk_store_cause: assert property (verifier_store_out |->
    $past(verifier_armed_out && code_read_ok_in))
    else $error("store without armed good read");
endmodule

bind scanner_input_conditioner input_cond_checker #(.SHORT_CYCLES(SHORT_CYCLES))
  u_input_cond_checker (
  .clock_in(clock_in), .reset_in(reset_in), .trigger_input_in(trigger_input_in),
  .config_in(config_in), .mode_in(mode_in), .code_read_ok_in(code_read_ok_in),
  .state_out(state_out), .phase_indicator_out(phase_indicator_out),
  .reading_phase_out(reading_phase_out), .scan_start_out(scan_start_out),
  .scan_stop_out(scan_stop_out), .encoder_pulse_out(encoder_pulse_out),
  .verifier_armed_out(verifier_armed_out), .verifier_store_out(verifier_store_out));

// File: bench/field_sensor_model.sv
/* Field side: presence sensor, conveyor encoder and two stop switches.
   Assumes the bench changes its commands just after a rising edge. */
`timescale 1ns/1ps
module field_sensor_model #(
  parameter int unsigned ENC_HALF = 10
) (
  // clock and commands
  input wire logic clock_in,
  input wire logic presence_in,
  input wire logic encoder_run_in,
  input wire logic [1:0] stop_in,
  // line levels, 1 = current flows
  output logic trigger_line_out,
  output logic encoder_line_out,
  output logic [1:0] generic_line_out
);
  int unsigned ticks = 0;
  initial encoder_line_out = 1'b0;
  assign trigger_line_out = presence_in;
  assign generic_line_out = stop_in;
  // slow encoder, half period kept above the short delay
  always @(posedge clock_in) begin
    ticks <= (encoder_run_in && ticks < ENC_HALF - 1) ? ticks + 1 : 0;
    if (encoder_run_in && ticks == ENC_HALF - 1) encoder_line_out <= !encoder_line_out;
  end
endmodule

// File: bench/scanner_input_conditioner_tb_top.sv
/* Self-checking bench for the scanner input conditioner.
   Assumes short debounce counts set here; the field model drives the lines. */
`timescale 1ns/1ps
module scanner_input_conditioner_tb_top;
  import input_cond_pkg::*;
  localparam int unsigned LONG = 20;
  localparam int unsigned SHORT = 5;
  localparam int unsigned WIN = 200;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic presence = 1'b0;
  logic enc_run = 1'b0;
  logic [1:0] stop = 2'h0;
  logic trig_line, enc_line;
  logic [1:0] gen_line;
  input_config_s cfg = '{4'hf, 1'b1, 1'b1};
  operating_mode_e mode = mode_host_triggered;
  logic stop_en = 1'b0;
  logic ver_en = 1'b0;
  logic read_ok = 1'b0;
  input_state_s st;
  logic ind, phase, start, stp, spd_v, armed, store;
  logic enc_pulse;
  logic [15:0] speed;
  int fail_count = 0;
  int tests_run = 0;
  int n;
  always #50 clock_in = ~clock_in;
  field_sensor_model u_field_sensor_model (.clock_in(clock_in), .presence_in(presence),
    .encoder_run_in(enc_run), .stop_in(stop), .trigger_line_out(trig_line),
    .encoder_line_out(enc_line), .generic_line_out(gen_line));
  scanner_input_conditioner #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT), .WINDOW_CYCLES(WIN))
  u_scanner_input_conditioner (.clock_in(clock_in), .reset_in(reset_in),
    .trigger_input_in(trig_line), .encoder_input_in(enc_line),
    .generic_input_a_in(gen_line[1]), .generic_input_b_in(gen_line[0]), .config_in(cfg),
    .mode_in(mode), .generic_stop_enable_in(stop_en), .verifier_enable_in(ver_en),
    .verifier_input_select_in(2'h2), .code_read_ok_in(read_ok), .state_out(st),
    .phase_indicator_out(ind), .reading_phase_out(phase), .scan_start_out(start),
    .scan_stop_out(stp), .encoder_speed_out(speed), .speed_valid_out(spd_v),
    .encoder_pulse_out(enc_pulse), .verifier_armed_out(armed), .verifier_store_out(store));
  // ==========================================
  // shared tasks
  task automatic step(input int k);
    repeat (k) @(posedge clock_in);
    #10;
  endtask
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bounded wait on one output picked by k; n counts the cycles
  task automatic wait_on(input int k, input int lim);
    logic s;
    n = 0;
    do begin
      step(1);
      n++;
      s = (k == 0) ? start : (k == 1) ? stp : (k == 2) ? spd_v :
          (k == 3) ? st.trigger_input : store;
    end while (s !== 1'b1 && n < lim);
    if (s !== 1'b1) begin
      fail_count++;
      $display("Error wait %0d expected 1 seen %b", k, s);
      end_of_test();
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // test sequence
  initial begin
    step(4);
    reset_in = 1'b0;
    step(2);
    check("state", 16'h0, {12'h0, st});
    presence = 1'b1;
    step(SHORT - 2);
    presence = 1'b0;
    step(SHORT + 6);
    check("glitch", 16'h0, {15'h0, ind});
    $display("test reset and glitch ends");
    cfg.shared_short_debounce = 1'b0;
    presence = 1'b1;
    wait_on(3, LONG + 10);
    check("delay", 16'h1, {15'h0, n >= LONG && n <= LONG + 4});
    // start pulse leaves the same edge as state_out
    check("start", 16'h1, {15'h0, start});
    check("indicator", 16'h1, {15'h0, ind});
    stop_en = 1'b1;
    for (int i = 0; i < 2; i++) begin
      stop = 2'h1 << i;
      wait_on(1, LONG + 10);
      check("phase", 16'h0, {15'h0, phase});
      stop = 2'h0;
      presence = 1'b0;
      step(LONG + 6);
      presence = 1'b1;
      wait_on(0, LONG + 10);
    end
    stop_en = 1'b0;
    presence = 1'b0;
    wait_on(1, LONG + 10);
    $display("test start and stop ends");
    mode = mode_free_running;
    presence = 1'b1;
    n = 0;
    repeat (LONG + 8) begin
      step(1);
      n += start;
    end
    check("free start", 16'h0, n[15:0]);
    presence = 1'b0;
    step(LONG + 6);
    mode = mode_conveyor_tracking;
    presence = 1'b1;
    wait_on(0, LONG + 10);
    enc_run = 1'b1;
    wait_on(2, WIN + 10);
    wait_on(2, WIN + 10);
    check("speed", 16'ha, speed);
    // steady encoder: one pulse per full period over a whole window
    n = 0;
    repeat (WIN) begin
      step(1);
      n += enc_pulse;
    end
    check("pulses", 16'ha, n[15:0]);
    enc_run = 1'b0;
    $display("test modes and speed ends");
    ver_en = 1'b1;
    stop = 2'h2;
    step(LONG + 6);
    check("armed", 16'h1, {15'h0, armed});
    check("gen a", 16'h1, {15'h0, st.generic_input_a});
    read_ok = 1'b1;
    step(1);
    read_ok = 1'b0;
    check("store", 16'h1, {15'h0, store});
    step(1);
    check("disarm", 16'h0, {15'h0, armed});
    $display("test verifier ends");
    mode = mode_free_running;
    presence = 1'b0;
    step(LONG + 6);
    cfg.active_closed[3] = 1'b0;
    step(2);
    check("open trig", 16'h1, {15'h0, st.trigger_input});
    check("open led", 16'h0, {15'h0, ind});
    $display("test polarity ends");
    end_of_test();
  end
endmodule
